// ===== core/can_irq_pkg.sv
package can_irq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets (byte address on the plain register port)
	localparam logic [7:0] TX_ERR_COUNT_ADDR  = 8'h1C;
	localparam logic [7:0] RX_ERR_COUNT_ADDR  = 8'h1D;
	localparam logic [7:0] ENABLES_ADDR       = 8'h2B;
	localparam logic [7:0] FLAGS_ADDR         = 8'h2C;
	localparam logic [7:0] ERROR_FLAGS_ADDR   = 8'h2D;
	localparam logic [7:0] CONTROL_ADDR       = 8'h0F;
	localparam logic [7:0] STATUS_ADDR        = 8'h0E;

	////////////////////////////////////////////////////////////////////////////
	// Error flag register bit positions
	localparam int RX1_OVR_BIT  = 7;
	localparam int RX0_OVR_BIT  = 6;
	localparam int BUS_OFF_BIT  = 5;
	localparam int TX_PASS_BIT  = 4;
	localparam int RX_PASS_BIT  = 3;
	localparam int TX_WARN_BIT  = 2;
	localparam int RX_WARN_BIT  = 1;
	localparam int ANY_WARN_BIT = 0;

	// Interrupt enable / flag register bit positions
	localparam int MERR_BIT = 7;
	localparam int WAKE_BIT = 6;
	localparam int ERR_BIT  = 5;
	localparam int TX2_BIT  = 4;
	localparam int TX1_BIT  = 3;
	localparam int TX0_BIT  = 2;
	localparam int RX1_BIT  = 1;
	localparam int RX0_BIT  = 0;

	// Control register bit positions
	localparam int CTRL_CONFIG_BIT = 1;
	localparam int CTRL_SLEEP_BIT  = 0;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and thresholds
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [7:0] CTRL_RESET      = 8'h02;
	localparam logic [7:0] WARN_LIMIT      = 8'h60;
	localparam logic [7:0] PASSIVE_LIMIT   = 8'h80;
	localparam logic [7:0] BUS_OFF_LIMIT   = 8'hFF;
	localparam logic [7:0] COUNT_MAX       = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// Interrupt codes, lower is more urgent
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_ERR  = 3'h1;
	localparam logic [2:0] CODE_WAKE = 3'h2;
	localparam logic [2:0] CODE_TX0  = 3'h3;
	localparam logic [2:0] CODE_TX1  = 3'h4;
	localparam logic [2:0] CODE_TX2  = 3'h5;
	localparam logic [2:0] CODE_RX0  = 3'h6;
	localparam logic [2:0] CODE_RX1  = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// Events from the protocol engine, one-cycle pulses
	typedef struct packed {
		logic       rx0_loaded;
		logic       rx1_loaded;
		logic [2:0] tx_emptied;
		logic       msg_error;
		logic       bus_activity;
		logic       tx_err_inc1;
		logic       tx_err_inc8;
		logic       tx_err_dec;
		logic       rx_err_inc1;
		logic       rx_err_inc8;
		logic       rx_err_dec;
		logic       recovery_done;
	} can_evt_t;

	// Entire block state
	typedef struct packed {
		logic [7:0] enables;
		logic [7:0] flags;
		logic [1:0] overflow;
		logic       bus_off;
		logic [7:0] tx_count;
		logic [7:0] rx_count;
		logic [4:0] state_prev;
		logic [1:0] control;
		logic [7:0] rdata;
	} irq_state_t;

endpackage

// ===== core/can_error_flag_and_interrupt_unit.sv
// What this block does
// - Buffer 1 overflow flag sets on accept while buffer 1 full; host clears.
// - Buffer 0 overflow flag sets on accept while buffer 0 full; host clears.
// - Bus-off flag sets at transmit count 255, clears after recovery sequence.
// - Transmit passive flag follows transmit count at or above 128.
// - Receive passive flag follows receive count at or above 128.
// - Transmit warning flag follows transmit count at or above 96.
// - Receive warning flag follows receive count at or above 96.
// - Combined warning flag is OR of both warning flags.
// - Eight interrupt sources, each with enable bit and pending flag.
// - Interrupt pin low while any enabled flag is pending.
// - Host clear is ignored while the setting condition still holds.
// - Host may set flags; an enabled set flag raises the interrupt.
// - Three-bit code names highest-priority pending source other than message error, which has no code; lower code wins.
// - Disabled sources are left out of the interrupt code.
// - Transmit-empty flag sets when its buffer empties; host writes zero.
// - Receive-full flag sets when a message loads into that buffer.
// - Message-error flag sets on any transmit or receive error.
// - In sleep with wake enabled, bus activity sets wake flag and ends sleep.
// - Error flag sets on overflow or any error-state flag change.
// - Overflow is an accepted message whose receive buffer is still full.
// - Enable and flag registers share one layout, all bits reset to zero.
// - Error counters follow bus rules and are readable by the host.
// - Error counters clear whenever configuration mode is entered.
`timescale 1ns/10ps

module can_error_flag_and_interrupt_unit
	import can_irq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	// Register port
	input  wire reg_req_t   reg_req_in,
	output logic [7:0]      reg_rdata_out,
	// Protocol engine events
	input  wire can_evt_t   can_evt_in,
	// Interrupt and status
	output logic            irq_n_out,
	output logic [2:0]      interrupt_code_out,
	output logic            wake_request_out,
	output logic            config_mode_out,
	output logic            sleep_mode_out
);

	////////////////////////////////////////////////////////////////////////////
	// State registers
	irq_state_t state_r;
	irq_state_t state_nxt;

	logic [7:0] error_flags;
	logic [4:0] state_now;
	logic [7:0] enabled_pending;
	logic [7:0] hw_set;
	logic [7:0] write_val;
	logic       wr_enables;
	logic       wr_flags;
	logic       wr_eflags;
	logic       wr_ctrl;
	logic [1:0] ovr_set;
	logic       state_changed;

	// Error flag bits by name
	logic       bus_off_flag;
	logic       tx_passive_flag;
	logic       rx_passive_flag;
	logic       tx_warning_flag;
	logic       rx_warning_flag;
	logic       combined_warning_flag;
	logic       rx_buffer1_overflow;
	logic       rx_buffer0_overflow;
	// Read strobe decode
	logic       rd_enables;
	logic       rd_flags;
	logic       rd_eflags;
	logic       rd_tx_count;
	logic       rd_rx_count;
	logic       rd_ctrl;
	logic       rd_status;
	// Next values worked out ahead of the state copy
	logic [7:0] flags_nxt;
	logic [1:0] overflow_nxt;
	logic       bus_off_nxt;
	logic [7:0] tx_count_nxt;
	logic [7:0] rx_count_nxt;
	logic [1:0] control_nxt;
	logic [7:0] rdata_nxt;
	logic       recovery_ok;
	logic       config_now;

	////////////////////////////////////////////////////////////////////////////
	// Error state decode from counters, bus-off latch and overflow bits
	always_comb
	begin
		bus_off_flag          = state_r.bus_off;
		tx_passive_flag       = (state_r.tx_count >= PASSIVE_LIMIT);
		rx_passive_flag       = (state_r.rx_count >= PASSIVE_LIMIT);
		tx_warning_flag       = (state_r.tx_count >= WARN_LIMIT);
		rx_warning_flag       = (state_r.rx_count >= WARN_LIMIT);
		combined_warning_flag = tx_warning_flag | rx_warning_flag;
		rx_buffer1_overflow   = state_r.overflow[1];
		rx_buffer0_overflow   = state_r.overflow[0];
		state_now = {bus_off_flag, tx_passive_flag, rx_passive_flag,
			tx_warning_flag, rx_warning_flag};
	end

	// Error flag register image, one bit per named flag
	always_comb
	begin
		error_flags               = REG_RESET;
		error_flags[RX1_OVR_BIT]  = rx_buffer1_overflow;
		error_flags[RX0_OVR_BIT]  = rx_buffer0_overflow;
		error_flags[BUS_OFF_BIT]  = bus_off_flag;
		error_flags[TX_PASS_BIT]  = tx_passive_flag;
		error_flags[RX_PASS_BIT]  = rx_passive_flag;
		error_flags[TX_WARN_BIT]  = tx_warning_flag;
		error_flags[RX_WARN_BIT]  = rx_warning_flag;
		error_flags[ANY_WARN_BIT] = combined_warning_flag;
	end

	// Register write decode
	always_comb
	begin
		wr_enables = 1'b0;
		wr_flags   = 1'b0;
		wr_eflags  = 1'b0;
		wr_ctrl    = 1'b0;
		write_val  = reg_req_in.wdata;
		if (reg_req_in.wr && reg_req_in.addr == ENABLES_ADDR)
			wr_enables = 1'b1;
		else if (reg_req_in.wr && reg_req_in.addr == FLAGS_ADDR)
			wr_flags = 1'b1;
		else if (reg_req_in.wr && reg_req_in.addr == ERROR_FLAGS_ADDR)
			wr_eflags = 1'b1;
		else if (reg_req_in.wr && reg_req_in.addr == CONTROL_ADDR)
			wr_ctrl = 1'b1;
	end

	// Register read decode
	always_comb
	begin
		rd_enables  = 1'b0;
		rd_flags    = 1'b0;
		rd_eflags   = 1'b0;
		rd_tx_count = 1'b0;
		rd_rx_count = 1'b0;
		rd_ctrl     = 1'b0;
		rd_status   = 1'b0;
		if (reg_req_in.rd && reg_req_in.addr == ENABLES_ADDR)
			rd_enables = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == FLAGS_ADDR)
			rd_flags = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == ERROR_FLAGS_ADDR)
			rd_eflags = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == TX_ERR_COUNT_ADDR)
			rd_tx_count = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == RX_ERR_COUNT_ADDR)
			rd_rx_count = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == CONTROL_ADDR)
			rd_ctrl = 1'b1;
		else if (reg_req_in.rd && reg_req_in.addr == STATUS_ADDR)
			rd_status = 1'b1;
	end

	// Overflow and error-state change detect
	always_comb
	begin
		ovr_set[1] = can_evt_in.rx1_loaded && state_r.flags[RX1_BIT];
		ovr_set[0] = can_evt_in.rx0_loaded && state_r.flags[RX0_BIT];
		state_changed = (state_now != state_r.state_prev);
	end

	// Hardware flag set conditions
	always_comb
	begin
		hw_set = 8'h00;
		hw_set[RX0_BIT]  = can_evt_in.rx0_loaded;
		hw_set[RX1_BIT]  = can_evt_in.rx1_loaded;
		hw_set[TX0_BIT]  = can_evt_in.tx_emptied[0];
		hw_set[TX1_BIT]  = can_evt_in.tx_emptied[1];
		hw_set[TX2_BIT]  = can_evt_in.tx_emptied[2];
		hw_set[MERR_BIT] = can_evt_in.msg_error;
		hw_set[WAKE_BIT] = can_evt_in.bus_activity && state_r.control[CTRL_SLEEP_BIT]
			&& state_r.enables[WAKE_BIT];
		hw_set[ERR_BIT]  = (|ovr_set) || state_changed;
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags: host write, then hardware sets win, so a clear in the cycle of a
	// set is refused
	always_comb
	begin
		flags_nxt = state_r.flags;
		if (wr_flags)
			flags_nxt = write_val | (state_r.flags & hw_set);
		flags_nxt = flags_nxt | hw_set;
	end

	// Overflow bits, only host writes of zero clear them
	always_comb
	begin
		overflow_nxt = state_r.overflow;
		if (wr_eflags)
			overflow_nxt = state_r.overflow & write_val[RX1_OVR_BIT:RX0_OVR_BIT];
		overflow_nxt = overflow_nxt | ovr_set;
	end

	// Bus-off latch; a finished recovery beats the saturated count
	always_comb
	begin
		recovery_ok = can_evt_in.recovery_done && state_r.bus_off;
		bus_off_nxt = state_r.bus_off;
		if (recovery_ok)
			bus_off_nxt = 1'b0;
		else if (state_r.tx_count == BUS_OFF_LIMIT)
			bus_off_nxt = 1'b1;
		if (config_now)
			bus_off_nxt = 1'b0;
	end

	// Transmit error counter, saturating at both ends
	always_comb
	begin
		tx_count_nxt = state_r.tx_count;
		if (can_evt_in.tx_err_inc8)
			tx_count_nxt = (state_r.tx_count > COUNT_MAX - 8'h08) ? COUNT_MAX
				: state_r.tx_count + 8'h08;
		else if (can_evt_in.tx_err_inc1)
			tx_count_nxt = (state_r.tx_count == COUNT_MAX) ? COUNT_MAX
				: state_r.tx_count + 8'h01;
		else if (can_evt_in.tx_err_dec && state_r.tx_count != 8'h00)
			tx_count_nxt = state_r.tx_count - 8'h01;
		// Recovery restarts the count once bus-off ends
		if (recovery_ok)
			tx_count_nxt = 8'h00;
		// Held at zero while in configuration mode
		if (config_now)
			tx_count_nxt = 8'h00;
	end

	// Receive error counter, saturating at both ends
	always_comb
	begin
		rx_count_nxt = state_r.rx_count;
		if (can_evt_in.rx_err_inc8)
			rx_count_nxt = (state_r.rx_count > COUNT_MAX - 8'h08) ? COUNT_MAX
				: state_r.rx_count + 8'h08;
		else if (can_evt_in.rx_err_inc1)
			rx_count_nxt = (state_r.rx_count == COUNT_MAX) ? COUNT_MAX
				: state_r.rx_count + 8'h01;
		else if (can_evt_in.rx_err_dec && state_r.rx_count != 8'h00)
			rx_count_nxt = state_r.rx_count - 8'h01;
		// Held at zero while in configuration mode
		if (config_now)
			rx_count_nxt = 8'h00;
	end

	// Mode control; wake event leaves sleep
	always_comb
	begin
		control_nxt = state_r.control;
		if (wr_ctrl)
			control_nxt = write_val[1:0];
		if (hw_set[WAKE_BIT])
			control_nxt[CTRL_SLEEP_BIT] = 1'b0;
		config_now = control_nxt[CTRL_CONFIG_BIT];
	end

	// Read data, one cycle after the strobe
	always_comb
	begin
		rdata_nxt = UNMAPPED_READ;
		if (rd_enables)
			rdata_nxt = state_r.enables;
		else if (rd_flags)
			rdata_nxt = state_r.flags;
		else if (rd_eflags)
			rdata_nxt = error_flags;
		else if (rd_tx_count)
			rdata_nxt = state_r.tx_count;
		else if (rd_rx_count)
			rdata_nxt = state_r.rx_count;
		else if (rd_ctrl)
			rdata_nxt = {6'h00, state_r.control};
		else if (rd_status)
			rdata_nxt = {1'b0, interrupt_code_out, 2'h0, state_r.control};
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state, one copy of every field
	always_comb
	begin
		state_nxt = state_r;
		if (wr_enables)
			state_nxt.enables = write_val;
		state_nxt.flags      = flags_nxt;
		state_nxt.overflow   = overflow_nxt;
		state_nxt.bus_off    = bus_off_nxt;
		state_nxt.tx_count   = tx_count_nxt;
		state_nxt.rx_count   = rx_count_nxt;
		state_nxt.state_prev = state_now;
		state_nxt.control    = control_nxt;
		state_nxt.rdata      = rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_r            <= '0;
			state_r.enables    <= REG_RESET;
			state_r.flags      <= REG_RESET;
			state_r.control    <= CTRL_RESET[1:0];
		end
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt output and priority code
	assign enabled_pending = state_r.flags & state_r.enables;
	assign irq_n_out       = ~(|enabled_pending);

	always_comb
	begin
		if (enabled_pending[ERR_BIT])
			interrupt_code_out = CODE_ERR;
		else if (enabled_pending[WAKE_BIT])
			interrupt_code_out = CODE_WAKE;
		else if (enabled_pending[TX0_BIT])
			interrupt_code_out = CODE_TX0;
		else if (enabled_pending[TX1_BIT])
			interrupt_code_out = CODE_TX1;
		else if (enabled_pending[TX2_BIT])
			interrupt_code_out = CODE_TX2;
		else if (enabled_pending[RX0_BIT])
			interrupt_code_out = CODE_RX0;
		else if (enabled_pending[RX1_BIT])
			interrupt_code_out = CODE_RX1;
		else
			interrupt_code_out = CODE_NONE;
	end

	// Status outputs
	assign reg_rdata_out    = state_r.rdata;
	assign wake_request_out = state_r.flags[WAKE_BIT] & state_r.enables[WAKE_BIT];
	assign config_mode_out  = state_r.control[CTRL_CONFIG_BIT];
	assign sleep_mode_out   = state_r.control[CTRL_SLEEP_BIT];

endmodule

// ===== dv/can_irq_monitor.sv
`timescale 1ns/10ps
module can_irq_monitor
	import can_irq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	// Register port
	input  wire reg_req_t   reg_req_in,
	input  wire logic [7:0] reg_rdata_out,
	// Events and status
	input  wire can_evt_t   can_evt_in,
	input  wire logic       irq_n_out,
	input  wire logic [2:0] interrupt_code_out,
	input  wire logic       wake_request_out,
	input  wire logic       config_mode_out,
	input  wire logic       sleep_mode_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////
	// Host write steps
	sequence s_en_all;
		reg_req_in.wr && reg_req_in.addr == ENABLES_ADDR && reg_req_in.wdata == 8'hFF;
	endsequence
	sequence s_flags_wr(logic [7:0] v);
		reg_req_in.wr && reg_req_in.addr == FLAGS_ADDR && reg_req_in.wdata == v;
	endsequence
	property p_idle_code;
		irq_n_out |-> interrupt_code_out == CODE_NONE;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("code while idle");
	property p_code_irq;
		interrupt_code_out != CODE_NONE |-> !irq_n_out;
	endproperty
	a_code_irq: assert property (p_code_irq) else $error("code without irq");
	property p_wake_irq;
		wake_request_out |-> !irq_n_out && interrupt_code_out <= CODE_WAKE;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake not raised");
	property p_wake_refuse;
		can_evt_in.bus_activity && !sleep_mode_out && !reg_req_in.wr |=> !$rose(wake_request_out);
	endproperty
	a_wake_refuse: assert property (p_wake_refuse) else $error("wake when awake");
	property p_host_set;
		s_en_all ##1 s_flags_wr(8'h02) |=> !irq_n_out && interrupt_code_out == CODE_RX1;
	endproperty
	a_host_set: assert property (p_host_set) else $error("host set lost");
	property p_merr_code;
		s_en_all ##1 s_flags_wr(8'h80) |=> !irq_n_out && interrupt_code_out == CODE_NONE;
	endproperty
	a_merr_code: assert property (p_merr_code) else $error("message error irq");
	property p_set_wins;
		s_en_all ##1 (s_flags_wr(8'h00) ##0 can_evt_in.rx0_loaded) |=> interrupt_code_out == CODE_RX0;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");
	property p_count_clear;
		reg_req_in.rd && reg_req_in.addr[7:1] == 7'h0E && config_mode_out && $past(config_mode_out)
			|=> reg_rdata_out == 8'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("count kept");
	property p_reset;
		$rose(reset_n_in) |-> irq_n_out && config_mode_out && interrupt_code_out == CODE_NONE;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");
endmodule

// ===== dv/can_engine_model.sv
`timescale 1ns/10ps
module can_engine_model
	import can_irq_pkg::*;
(
	// Clock
	input  wire logic clk_in,
	// Event pulses
	output can_evt_t  can_evt_out
);
	initial can_evt_out = '0;
	// One-cycle pulse, entered right after an edge
	task automatic pulse(input can_evt_t e);
		can_evt_out <= e;
		@(posedge clk_in);
		can_evt_out <= '0;
	endtask
endmodule

// ===== dv/can_error_flag_and_interrupt_unit_tb.sv
`timescale 1ns/10ps
module can_error_flag_and_interrupt_unit_tb
	import can_irq_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	reg_req_t    req = '0;
	can_evt_t    evt;
	logic [7:0]  rdata;
	logic        irq_n;
	logic [2:0]  code;
	logic        rd_seen = 1'b0;
	logic [11:0] notes[$];
	int          n_errors = 0;
	int          total_checks = 0;
	logic [7:0]  f;
	int          pos[7] = '{5, 6, 2, 3, 4, 0, 1};
	// Clock
	always #10 clk_in = ~clk_in;
	can_error_flag_and_interrupt_unit i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.reg_req_in(req), .reg_rdata_out(rdata), .can_evt_in(evt), .irq_n_out(irq_n),
		.interrupt_code_out(code), .wake_request_out(), .config_mode_out(), .sleep_mode_out());
	can_engine_model i_eng (.clk_in(clk_in), .can_evt_out(evt));
	////////////////////////////////
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done;
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One bus cycle, held until the next edge
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{addr: a, wdata: d, wr: w, rd: r};
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic n, input logic [2:0] c, input logic [7:0] d);
		notes.push_back({n, c, d});
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic ev(input can_evt_t e, input int n);
		repeat (n)
		begin
			bus(1'b0, 1'b0, 8'h00, 8'h00);
			i_eng.pulse(e);
		end
	endtask
	// Answer watcher: pins and read data against the oldest note
	always @(posedge clk_in)
	begin
		if (rd_seen)
			check("irq code rdata", notes.pop_front(), {irq_n, code, rdata});
		rd_seen <= req.rd;
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk_in);
		n_errors++;
		test_done;
	end
	////////////////////////////////
	initial
	begin
		void'($urandom(32'hc3ef));
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rd(ENABLES_ADDR, 1'b1, CODE_NONE, 8'h00);
		rd(FLAGS_ADDR, 1'b1, CODE_NONE, 8'h00);
		rd(8'h55, 1'b1, CODE_NONE, UNMAPPED_READ);
		f = 8'($urandom);
		wr(ENABLES_ADDR, f);
		rd(ENABLES_ADDR, 1'b1, CODE_NONE, f);
		wr(ENABLES_ADDR, 8'h00);
		wr(CONTROL_ADDR, 8'h00);
		// Error counts across the limits
		ev('{tx_err_inc8: 1'b1, default: '0}, 11);
		ev('{tx_err_inc1: 1'b1, default: '0}, 7);
		rd(ERROR_FLAGS_ADDR, 1'b1, CODE_NONE, 8'h00);
		rd(TX_ERR_COUNT_ADDR, 1'b1, CODE_NONE, 8'h5F);
		ev('{tx_err_inc1: 1'b1, default: '0}, 1);
		rd(ERROR_FLAGS_ADDR, 1'b1, CODE_NONE, 8'h05);
		ev('{tx_err_inc8: 1'b1, default: '0}, 4);
		rd(ERROR_FLAGS_ADDR, 1'b1, CODE_NONE, 8'h15);
		ev('{rx_err_inc8: 1'b1, default: '0}, 16);
		ev('{tx_err_inc8: 1'b1, default: '0}, 16);
		rd(ERROR_FLAGS_ADDR, 1'b1, CODE_NONE, 8'h3F);
		ev('{recovery_done: 1'b1, default: '0}, 1);
		ev('{rx_err_dec: 1'b1, default: '0}, 1);
		rd(ERROR_FLAGS_ADDR, 1'b1, CODE_NONE, 8'h03);
		rd(FLAGS_ADDR, 1'b1, CODE_NONE, 8'h20);
		wr(CONTROL_ADDR, 8'h02);
		ev('0, 2);
		rd(RX_ERR_COUNT_ADDR, 1'b1, CODE_NONE, 8'h00);
		// Host-set flags and the priority order
		wr(FLAGS_ADDR, 8'h00);
		wr(ENABLES_ADDR, 8'hFF);
		wr(FLAGS_ADDR, 8'h02);
		rd(FLAGS_ADDR, 1'b0, CODE_RX1, 8'h02);
		wr(ENABLES_ADDR, 8'hFF);
		wr(FLAGS_ADDR, 8'h80);
		rd(FLAGS_ADDR, 1'b0, CODE_NONE, 8'h80);
		f = 8'h00;
		for (int c = 7; c >= 1; c--)
		begin
			f[pos[c - 1]] = 1'b1;
			wr(FLAGS_ADDR, f);
			rd(FLAGS_ADDR, 1'b0, 3'(c), f);
		end
		wr(ENABLES_ADDR, 8'hDF);
		rd(STATUS_ADDR, 1'b0, CODE_WAKE, 8'h22);
		wr(ENABLES_ADDR, 8'h00);
		rd(FLAGS_ADDR, 1'b1, CODE_NONE, 8'h7F);
		// Clear racing a buffer load; flags cleared first while no source is active
		wr(FLAGS_ADDR, 8'h00);
		wr(ENABLES_ADDR, 8'hFF);
		fork
			begin
				wr(FLAGS_ADDR, 8'h00);
				bus(1'b0, 1'b0, 8'h00, 8'h00);
			end
			begin
				@(posedge clk_in);
				i_eng.pulse('{rx0_loaded: 1'b1, default: '0});
			end
		join
		rd(FLAGS_ADDR, 1'b0, CODE_RX0, 8'h01);
		// Overflow of both receive buffers, transmit empties
		ev('{rx1_loaded: 1'b1, default: '0}, 1);
		ev('{rx0_loaded: 1'b1, rx1_loaded: 1'b1, default: '0}, 1);
		ev('{tx_emptied: 3'b101, default: '0}, 1);
		rd(ERROR_FLAGS_ADDR, 1'b0, CODE_ERR, 8'hC0);
		rd(FLAGS_ADDR, 1'b0, CODE_ERR, 8'h37);
		wr(ERROR_FLAGS_ADDR, 8'h00);
		rd(ERROR_FLAGS_ADDR, 1'b0, CODE_ERR, 8'h00);
		// Wake from sleep, then bus activity while awake
		wr(FLAGS_ADDR, 8'h00);
		wr(CONTROL_ADDR, 8'h01);
		ev('{bus_activity: 1'b1, default: '0}, 1);
		rd(STATUS_ADDR, 1'b0, CODE_WAKE, 8'h20);
		ev('{msg_error: 1'b1, default: '0}, 1);
		rd(FLAGS_ADDR, 1'b0, CODE_WAKE, 8'hC0);
		wr(FLAGS_ADDR, 8'h00);
		ev('{bus_activity: 1'b1, default: '0}, 1);
		rd(FLAGS_ADDR, 1'b1, CODE_NONE, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (2) @(posedge clk_in);
		test_done;
	end
endmodule
////////////////////////////////
bind can_error_flag_and_interrupt_unit can_irq_monitor i_mon (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
	.can_evt_in(can_evt_in), .irq_n_out(irq_n_out), .interrupt_code_out(interrupt_code_out),
	.wake_request_out(wake_request_out), .config_mode_out(config_mode_out),
	.sleep_mode_out(sleep_mode_out));
